// *** hw/ring_wake_pkg.sv ***
package ring_wake_pkg;
    // =====================================================================
    // Register map.
    localparam logic [7:0] RING_FILTER_SELECT_OFS = 8'hC6;
    localparam logic [7:0] PIN_A_CONFIG_OFS = 8'hE0;
    localparam logic [7:0] PIN_B_CONFIG_OFS = 8'hE1;
    localparam logic [7:0] WAKE_STATUS_OFS = 8'hF0;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'hF1;
    localparam logic [7:0] IRQ_MASK_OFS = 8'hF2;
    localparam logic [7:0] PIN_LEVEL_OFS = 8'hF3;
    localparam logic [7:0] PIN_OUT_OFS = 8'hF4;
    // =====================================================================
    // Reset values.
    localparam logic [7:0] RING_FILTER_SELECT_RST = 8'h00;
    localparam logic [7:0] PIN_CONFIG_RST = 8'h01;
    // =====================================================================
    // Field positions of the pin configuration registers.
    localparam int CFG_DIR_BIT = 0;
    localparam int CFG_POL_BIT = 1;
    localparam int CFG_GRP_BIT = 2;
    localparam int CFG_FN_LO_BIT = 3;
    localparam int CFG_FN_HI_BIT = 4;
    localparam int CFG_OD_BIT = 7;
    localparam logic [7:0] PIN_A_CFG_MASK = 8'h8F;
    localparam logic [7:0] PIN_B_CFG_MASK = 8'h9F;
    localparam logic [7:0] RING_SEL_MASK = 8'h07;
    localparam logic [1:0] FN_B_GPIO = 2'h0;
    localparam logic [1:0] FN_B_RING = 2'h1;
    localparam logic [1:0] FN_B_EDGE_IRQ = 2'h2;
    // =====================================================================
    // Interrupt status layout.
    localparam int IRQ_RING_WAKE_BIT = 0;
    localparam int IRQ_SER_A_BIT = 1;
    localparam int IRQ_SER_B_BIT = 2;
    localparam int IRQ_PIN_B_EDGE_BIT = 3;
    localparam int IRQ_GROUP_BIT = 4;
    localparam int IRQ_WIDTH = 5;
    // =====================================================================
    // Timing: a train of at least 15 Hz has edges no more than about 67 ms apart.
    localparam longint CLOCK_HZ = 64'd20000000;
    localparam longint RING_GAP_MS = 64'd67;
    localparam longint RING_GAP_CYCLES = (CLOCK_HZ * RING_GAP_MS) / 64'd1000;
    localparam longint RING_QUALIFY_MS = 64'd200;
    localparam longint RING_QUALIFY_CYCLES = (CLOCK_HZ * RING_QUALIFY_MS) / 64'd1000;
endpackage : ring_wake_pkg

// *** hw/ring_filter_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ring_filter_if;
    logic filterOn;
    logic ringSync;
    logic ringOut_n;
    logic trigger;
    modport ctrl (output filterOn, output ringSync, input ringOut_n, input trigger);
    modport filt (input filterOn, input ringSync, output ringOut_n, output trigger);
endinterface : ring_filter_if
`default_nettype wire

// *** hw/ring_filter_chan.sv ***
`timescale 1ns/1ps
`default_nettype none
module ring_filter_chan #(
    parameter longint GAP_CYCLES = ring_wake_pkg::RING_GAP_CYCLES,
    parameter longint QUALIFY_CYCLES = ring_wake_pkg::RING_QUALIFY_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clkEn,
    ring_filter_if.filt rf
);
    // The counters are 24 bits wide, so larger counts cannot be served.
    if (GAP_CYCLES < 1 || QUALIFY_CYCLES < 1 || GAP_CYCLES >= 64'd16777216
        || QUALIFY_CYCLES >= 64'd16777216) begin : g_badCounts
        $error("ring_filter_chan: counts out of range");
    end

    localparam logic [23:0] GAP_C = 24'(GAP_CYCLES);
    localparam logic [23:0] QUAL_C = 24'(QUALIFY_CYCLES);

    logic prev_r;
    logic active_r;
    logic [23:0] gap_r;
    logic [23:0] run_r;
    logic qualified_r;
    logic outN_r;
    logic trig_r;

    // A falling edge on the already synchronised ring level.
    wire fallEdge = prev_r & ~rf.ringSync;
    wire gapExpired = active_r && (gap_r == GAP_C);
    wire qualifyNow = active_r && !qualified_r && (run_r == QUAL_C);
    // Raw mode passes each falling edge; filtered mode fires once a train qualifies.
    wire trigNxt = rf.filterOn ? qualifyNow : fallEdge;
    // Raw mode shows the synchronised ring level, so it is high while the line idles.
    wire outNNxt = rf.filterOn ? ~(qualified_r | qualifyNow) | gapExpired : rf.ringSync;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prev_r <= 1'b1;
            active_r <= 1'b0;
            gap_r <= 24'h000000;
            run_r <= 24'h000000;
            qualified_r <= 1'b0;
            outN_r <= 1'b1;
            trig_r <= 1'b0;
        end else if (clkEn) begin
            prev_r <= rf.ringSync;
            outN_r <= outNNxt;
            trig_r <= trigNxt;
            if (fallEdge) begin
                active_r <= 1'b1;
                gap_r <= 24'h000000;
            end else if (gapExpired || !rf.filterOn) begin
                active_r <= 1'b0;
            end else if (active_r) begin
                gap_r <= gap_r + 24'h000001;
            end
            if (!active_r || !rf.filterOn || gapExpired) begin
                run_r <= 24'h000000;
                qualified_r <= 1'b0;
            end else if (qualifyNow) begin
                qualified_r <= 1'b1;
            end else if (!qualified_r) begin
                run_r <= run_r + 24'h000001;
            end
        end
    end

    assign rf.ringOut_n = outN_r;
    assign rf.trigger = trig_r;
endmodule : ring_filter_chan
`default_nettype wire

// *** hw/ring_wake_filter_gpio_cfg.sv ***
`timescale 1ns/1ps
`default_nettype none
module ring_wake_filter_gpio_cfg #(
    parameter longint RING_GAP_CYCLES = ring_wake_pkg::RING_GAP_CYCLES,
    parameter longint RING_QUALIFY_CYCLES = ring_wake_pkg::RING_QUALIFY_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic ringWakeIn_n,
    input wire logic serialRingInA_n,
    input wire logic serialRingInB_n,
    input wire logic sysMgmtInt_n,
    input wire logic wakeLevelSrc,
    input wire logic wakeEdgeSrc,
    input wire logic auxPinAIn,
    output logic auxPinAOut,
    output logic auxPinAOe,
    input wire logic auxPinBIn,
    output logic auxPinBOut,
    output logic auxPinBOe,
    output logic ringIndicate_n,
    output logic powerOnReq,
    output logic groupIrq,
    output logic irq
);
    // =====================================================================
    // Input synchronisers.
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    wire [4:0] rawIn = {auxPinBIn, auxPinAIn, serialRingInB_n, serialRingInA_n, ringWakeIn_n};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_r <= 5'h1F;
            sync2_r <= 5'h1F;
        end else if (clkEn) begin
            sync1_r <= rawIn;
            sync2_r <= sync1_r;
        end
    end

    // =====================================================================
    // Configuration registers.
    localparam int IRQ_W = ring_wake_pkg::IRQ_WIDTH;
    logic [7:0] ringSel_r;
    logic [7:0] cfgA_r;
    logic [7:0] cfgB_r;
    logic [1:0] pinOut_r;
    logic [IRQ_W-1:0] irqMask_r;
    logic [IRQ_W-1:0] irqStat_r;
    logic [1:0] wakeLatch_r;
    logic [7:0] rdData_r;

    wire selRing = regAddr == ring_wake_pkg::RING_FILTER_SELECT_OFS;
    wire selCfgA = regAddr == ring_wake_pkg::PIN_A_CONFIG_OFS;
    wire selCfgB = regAddr == ring_wake_pkg::PIN_B_CONFIG_OFS;
    wire selWake = regAddr == ring_wake_pkg::WAKE_STATUS_OFS;
    wire selStat = regAddr == ring_wake_pkg::IRQ_STATUS_OFS;
    wire selMask = regAddr == ring_wake_pkg::IRQ_MASK_OFS;
    wire selLevel = regAddr == ring_wake_pkg::PIN_LEVEL_OFS;
    wire selOut = regAddr == ring_wake_pkg::PIN_OUT_OFS;

    // =====================================================================
    // Ring filter channels: ring wake input, serial ring A, serial ring B.
    wire [2:0] ringOutN;
    wire [2:0] ringTrig;
    wire pinBRing = cfgB_r[4:3] == ring_wake_pkg::FN_B_RING;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chan
            ring_filter_if rfi ();
            // Pin B joins the ring wake input when it is set to ring function; either line low is a ring.
            if (gi == 0) begin : g_src
                assign rfi.ringSync = sync2_r[0] & (~pinBRing | sync2_r[4]);
            end else begin : g_src
                assign rfi.ringSync = sync2_r[gi];
            end
            assign rfi.filterOn = ringSel_r[gi];
            assign ringOutN[gi] = rfi.ringOut_n;
            assign ringTrig[gi] = rfi.trigger;
            ring_filter_chan #(
                .GAP_CYCLES(RING_GAP_CYCLES),
                .QUALIFY_CYCLES(RING_QUALIFY_CYCLES)
            ) u_chan (
                .clock(clock),
                .rst(rst),
                .clkEn(clkEn),
                .rf(rfi.filt)
            );
        end
    endgenerate

    // =====================================================================
    // Pin logic.
    wire pinALogic = sync2_r[3] ^ cfgA_r[ring_wake_pkg::CFG_POL_BIT];
    wire pinBLogic = sync2_r[4] ^ cfgB_r[ring_wake_pkg::CFG_POL_BIT];
    logic pinBPrev_r;
    wire pinBEdge = (pinBLogic != pinBPrev_r)
        && (cfgB_r[4:3] == ring_wake_pkg::FN_B_EDGE_IRQ);
    // Reserved function 11 drives nothing and reads as general I/O input.
    wire pinAFnSmi = cfgA_r[ring_wake_pkg::CFG_FN_LO_BIT];
    wire pinBGpio = cfgB_r[4:3] == ring_wake_pkg::FN_B_GPIO;
    wire pinALevel = pinAFnSmi ? sysMgmtInt_n : (pinOut_r[0] ^ cfgA_r[1]);
    wire pinBLevel = pinOut_r[1] ^ cfgB_r[1];
    wire pinADrive = pinAFnSmi || !cfgA_r[ring_wake_pkg::CFG_DIR_BIT];
    wire pinBDrive = pinBGpio && !cfgB_r[ring_wake_pkg::CFG_DIR_BIT];
    wire groupNow = (cfgA_r[ring_wake_pkg::CFG_GRP_BIT] & cfgA_r[0] & pinALogic)
        | (cfgB_r[ring_wake_pkg::CFG_GRP_BIT] & cfgB_r[0] & pinBLogic);

    // Open drain drives only the low level; the pin floats otherwise.
    assign auxPinAOut = pinALevel;
    assign auxPinAOe = pinADrive && !(cfgA_r[ring_wake_pkg::CFG_OD_BIT] && pinALevel);
    assign auxPinBOut = pinBLevel;
    assign auxPinBOe = pinBDrive && !(cfgB_r[ring_wake_pkg::CFG_OD_BIT] && pinBLevel);
    assign groupIrq = groupNow;

    // =====================================================================
    // Wake events: bit 0 is first class (ring), bit 1 third class (edge source).
    logic wakeEdgePrev_r;
    wire wakeEdgeRise = wakeEdgeSrc & ~wakeEdgePrev_r;
    wire anyRingTrig = |ringTrig;
    wire wakeRead = regRead && selWake;
    assign powerOnReq = wakeLatch_r[0] | wakeLevelSrc;
    assign ringIndicate_n = &ringOutN;

    // =====================================================================
    // Interrupt status: set wins over a write-one clear in the same cycle.
    wire [IRQ_W-1:0] irqEvents = {groupNow, pinBEdge, ringTrig[2], ringTrig[1], ringTrig[0]};
    wire statWrite = regWrite && selStat;
    wire [IRQ_W-1:0] statClr = statWrite ? regWrData[IRQ_W-1:0] : {IRQ_W{1'b0}};
    assign irq = |(irqStat_r & irqMask_r);

    // =====================================================================
    // Read data, one cycle after the strobe; unmapped offsets read zero.
    wire [7:0] rdMux =
        selRing ? ringSel_r :
        selCfgA ? cfgA_r :
        selCfgB ? cfgB_r :
        selWake ? {6'h00, wakeLatch_r} :
        selStat ? {3'h0, irqStat_r} :
        selMask ? {3'h0, irqMask_r} :
        selLevel ? {6'h00, pinBLogic, pinALogic} :
        selOut ? {6'h00, pinOut_r} : 8'h00;
    assign regRdData = rdData_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ringSel_r <= ring_wake_pkg::RING_FILTER_SELECT_RST;
            cfgA_r <= ring_wake_pkg::PIN_CONFIG_RST;
            cfgB_r <= ring_wake_pkg::PIN_CONFIG_RST;
            pinOut_r <= 2'h0;
            irqMask_r <= {IRQ_W{1'b0}};
        end else if (clkEn && regWrite) begin
            if (selRing) begin
                ringSel_r <= regWrData & ring_wake_pkg::RING_SEL_MASK;
            end else if (selCfgA) begin
                cfgA_r <= regWrData & ring_wake_pkg::PIN_A_CFG_MASK;
            end else if (selCfgB) begin
                cfgB_r <= regWrData & ring_wake_pkg::PIN_B_CFG_MASK;
            end else if (selMask) begin
                irqMask_r <= regWrData[IRQ_W-1:0];
            end else if (selOut) begin
                pinOut_r <= regWrData[1:0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irqStat_r <= {IRQ_W{1'b0}};
            wakeLatch_r <= 2'h0;
            wakeEdgePrev_r <= 1'b0;
            // Matches the synchroniser's reset level, so no false edge follows reset.
            pinBPrev_r <= 1'b1;
            rdData_r <= 8'h00;
        end else if (clkEn) begin
            irqStat_r <= (irqStat_r & ~statClr) | irqEvents;
            // A read clears the latch, but an event in that cycle is kept.
            wakeLatch_r[0] <= (wakeLatch_r[0] & ~wakeRead) | anyRingTrig;
            wakeLatch_r[1] <= (wakeLatch_r[1] & ~wakeRead) | wakeEdgeRise;
            wakeEdgePrev_r <= wakeEdgeSrc;
            pinBPrev_r <= pinBLogic;
            rdData_r <= regRead ? rdMux : 8'h00;
        end
    end
endmodule : ring_wake_filter_gpio_cfg
`default_nettype wire

// *** tb/ring_wake_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker on the top ports, with shadows of the written configuration.
module ring_wake_properties (
    input wire logic clock,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    input wire logic ringWakeIn_n,
    input wire logic wakeLevelSrc,
    input wire logic wakeEdgeSrc,
    input wire logic auxPinAOut,
    input wire logic auxPinAOe,
    input wire logic ringIndicate_n,
    input wire logic powerOnReq,
    input wire logic groupIrq
);
    logic [7:0] cfgA_r;
    logic [7:0] cfgB_r;
    logic sel0_r;
    wire logic rdEn = regRead && clkEn;
    wire logic rdWake = rdEn && regAddr == 8'hF0;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfgA_r <= 8'h01;
            cfgB_r <= 8'h01;
            sel0_r <= 1'b0;
        end else if (regWrite && clkEn) begin
            if (regAddr == 8'hE0) cfgA_r <= regWrData & 8'h8F;
            if (regAddr == 8'hE1) cfgB_r <= regWrData & 8'h9F;
            if (regAddr == 8'hC6) sel0_r <= regWrData[0];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_rawFall;
        !sel0_r && $fell(ringWakeIn_n);
    endsequence
    sequence s_heldLow;
        (!ringWakeIn_n && clkEn) [*3];
    endsequence
    property p_rawRing;
        s_rawFall ##0 s_heldLow |-> ##[0:2] !ringIndicate_n;
    endproperty
    property p_rdIdle;
        !$past(rdEn) |-> regRdData == 8'h00;
    endproperty
    property p_cfgRead;
        rdEn && regAddr == 8'hE0 |=> regRdData == $past(cfgA_r);
    endproperty
    property p_levelWake;
        wakeLevelSrc |-> powerOnReq;
    endproperty
    property p_latchClear;
        $fell(powerOnReq) && !$past(wakeLevelSrc) |-> $past(rdWake);
    endproperty
    property p_edgeNoPower;
        $rose(wakeEdgeSrc) && !powerOnReq && !wakeLevelSrc && ringIndicate_n
            |=> !powerOnReq || wakeLevelSrc;
    endproperty
    property p_dirInput;
        cfgA_r[0] && !cfgA_r[3] |-> !auxPinAOe;
    endproperty
    property p_openDrain;
        cfgA_r[7] && auxPinAOut |-> !auxPinAOe;
    endproperty
    property p_groupOff;
        !cfgA_r[2] && !cfgB_r[2] |-> !groupIrq;
    endproperty
    a_rawRing: assert property (p_rawRing) else $error("raw ring edge missed");
    a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
    a_cfgRead: assert property (p_cfgRead) else $error("pin A config readback");
    a_levelWake: assert property (p_levelWake) else $error("level wake lost");
    a_latchClear: assert property (p_latchClear) else $error("latch cleared early");
    a_edgeNoPower: assert property (p_edgeNoPower) else $error("edge event powers on");
    a_dirInput: assert property (p_dirInput) else $error("input pin driven");
    a_openDrain: assert property (p_openDrain) else $error("open drain drives high");
    a_groupOff: assert property (p_groupOff) else $error("group without members");
endmodule : ring_wake_properties
bind ring_wake_filter_gpio_cfg ring_wake_properties u_props (
    .clock(clock), .rst(rst), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .ringWakeIn_n(ringWakeIn_n), .wakeLevelSrc(wakeLevelSrc), .wakeEdgeSrc(wakeEdgeSrc),
    .auxPinAOut(auxPinAOut), .auxPinAOe(auxPinAOe), .ringIndicate_n(ringIndicate_n),
    .powerOnReq(powerOnReq), .groupIrq(groupIrq));
`default_nettype wire

// *** tb/ring_line_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Ring lines of the modem side, idle high through their pull-ups.
module ring_line_model #(
    parameter int HALF = 4
) (
    input wire logic clock,
    input wire logic [2:0] burst,
    input wire logic [2:0] level_n,
    output logic [2:0] lines_n
);
    // One falling edge every 2 * HALF cycles keeps a burst inside the gap limit.
    int cnt_r = 0;
    logic phase_r = 1'b1;
    always @(posedge clock) begin
        cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
        if (cnt_r == HALF - 1) phase_r <= !phase_r;
    end
    assign lines_n = (burst & {3{phase_r}}) | (~burst & level_n);
endmodule : ring_line_model
`default_nettype wire

// *** tb/ring_wake_filter_gpio_cfg_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench with shortened ring timing: gap 20 cycles, qualify 60 cycles.
module ring_wake_filter_gpio_cfg_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic sysMgmtInt_n = 1'b1;
    logic wakeLevelSrc = 1'b0;
    logic wakeEdgeSrc = 1'b0;
    logic auxPinAIn = 1'b0;
    logic auxPinBIn = 1'b0;
    logic [2:0] burst = 3'h0;
    logic [2:0] level_n = 3'h7;
    logic [2:0] ring_n;
    logic [7:0] regRdData;
    logic [7:0] d;
    logic auxPinAOut, auxPinAOe, auxPinBOut, auxPinBOe, ringIndicate_n, powerOnReq, groupIrq, irq;
    int errors = 0;
    int checked = 0;
    always #25 clock = ~clock;
    ring_line_model #(.HALF(4)) u_line (.clock(clock), .burst(burst), .level_n(level_n),
        .lines_n(ring_n));
    ring_wake_filter_gpio_cfg #(.RING_GAP_CYCLES(20), .RING_QUALIFY_CYCLES(60)) u_dut (
        .clock(clock), .rst(rst), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .ringWakeIn_n(ring_n[0]), .serialRingInA_n(ring_n[1]), .serialRingInB_n(ring_n[2]),
        .sysMgmtInt_n(sysMgmtInt_n), .wakeLevelSrc(wakeLevelSrc), .wakeEdgeSrc(wakeEdgeSrc),
        .auxPinAIn(auxPinAIn), .auxPinAOut(auxPinAOut), .auxPinAOe(auxPinAOe),
        .auxPinBIn(auxPinBIn), .auxPinBOut(auxPinBOut), .auxPinBOe(auxPinBOe),
        .ringIndicate_n(ringIndicate_n), .powerOnReq(powerOnReq), .groupIrq(groupIrq),
        .irq(irq));
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
        rd(a);
        chk(what, d, exp);
    endtask : rdChk
    task automatic waitRing(input logic lvl, input int lim);
        for (int k = 0; k < lim && ringIndicate_n !== lvl; k++) cyc(1);
        chk("ringLevel", ringIndicate_n, lvl);
        if (ringIndicate_n !== lvl) end_of_test();
    endtask : waitRing
    task automatic t_registers();
        rdChk(8'hC6, 8'h00, "selRst");
        rdChk(8'hE0, 8'h01, "cfgARst");
        rdChk(8'hE1, 8'h01, "cfgBRst");
        rdChk(8'h10, 8'h00, "unmapped");
        wr(8'hE0, 8'hFF);
        rdChk(8'hE0, 8'h8F, "cfgAMask");
        wr(8'hE1, 8'hFF);
        rdChk(8'hE1, 8'h9F, "cfgBMask");
        wr(8'hC6, 8'hFF);
        rdChk(8'hC6, 8'h07, "selMask");
        // A write while the clock enable is low must leave the register alone.
        @(posedge clock);
        clkEn <= 1'b0;
        wr(8'hC6, 8'h01);
        clkEn <= 1'b1;
        rdChk(8'hC6, 8'h07, "frozen");
        wr(8'hE1, 8'h01);
    endtask : t_registers
    task automatic t_pinDrive();
        wr(8'hF4, 8'h03);
        wr(8'hE0, 8'h00);
        chk("aDrive", {auxPinAOe, auxPinAOut}, 8'h03);
        wr(8'hE0, 8'h02);
        chk("aInv", auxPinAOut, 8'h00);
        wr(8'hE0, 8'h80);
        chk("aOdHigh", auxPinAOe, 8'h00);
        wr(8'hF4, 8'h02);
        chk("aOdLow", {auxPinAOe, auxPinAOut}, 8'h02);
        wr(8'hE0, 8'h08);
        chk("aSmiHigh", auxPinAOut, 8'h01);
        @(posedge clock);
        sysMgmtInt_n <= 1'b0;
        cyc(2);
        chk("aSmiLow", auxPinAOut, 8'h00);
        wr(8'hE1, 8'h00);
        chk("bDrive", {auxPinBOe, auxPinBOut}, 8'h03);
        wr(8'hE0, 8'h01);
        wr(8'hE1, 8'h01);
        chk("inputs", {auxPinAOe, auxPinBOe}, 8'h00);
        sysMgmtInt_n <= 1'b1;
    endtask : t_pinDrive
    task automatic t_pinInput();
        @(posedge clock);
        auxPinAIn <= 1'b1;
        wr(8'hE0, 8'h05);
        cyc(3);
        rdChk(8'hF3, 8'h01, "levels");
        chk("grpOn", groupIrq, 8'h01);
        wr(8'hE0, 8'h03);
        rdChk(8'hF3, 8'h00, "levelsInv");
        wr(8'hE0, 8'h01);
        chk("grpOff", groupIrq, 8'h00);
        auxPinAIn <= 1'b0;
    endtask : t_pinInput
    task automatic t_edgeIrq();
        wr(8'hE1, 8'h11);
        wr(8'hF1, 8'h1F);
        wr(8'hF2, 8'h08);
        @(posedge clock);
        auxPinBIn <= 1'b1;
        cyc(5);
        chk("riseIrq", irq, 8'h01);
        rdChk(8'hF1, 8'h08, "edgeStat");
        wr(8'hF1, 8'h08);
        chk("clrIrq", irq, 8'h00);
        auxPinBIn <= 1'b0;
        cyc(5);
        wr(8'hF2, 8'h00);
        chk("maskIrq", irq, 8'h00);
        wr(8'hF2, 8'h08);
        chk("fallIrq", irq, 8'h01);
        wr(8'hF1, 8'h08);
        wr(8'hE1, 8'h01);
    endtask : t_edgeIrq
    task automatic t_rawRing();
        wr(8'hC6, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(8'hF1, 8'h1F);
            wr(8'hF2, 8'(8'h01 << i));
            level_n[i] <= 1'b0;
            cyc(5);
            chk("rawRing", {irq, ringIndicate_n}, 8'h02);
            rdChk(8'hF1, 8'(8'h01 << i), "rawStat");
            level_n[i] <= 1'b1;
            cyc(4);
            chk("rawIdle", ringIndicate_n, 8'h01);
            if (i == 0) begin
                chk("powerOn", powerOnReq, 8'h01);
                rdChk(8'hF0, 8'h01, "wakeLatch");
                chk("powerOff", powerOnReq, 8'h00);
            end
            rd(8'hF0);
        end
        // Pin B in ring function is raised first, so enabling it makes no edge.
        @(posedge clock);
        auxPinBIn <= 1'b1;
        wr(8'hE1, 8'h09);
        wr(8'hF1, 8'h1F);
        wr(8'hF2, 8'h01);
        @(posedge clock);
        auxPinBIn <= 1'b0;
        cyc(5);
        chk("pinBRing", {irq, ringIndicate_n}, 8'h02);
        auxPinBIn <= 1'b1;
        cyc(4);
        chk("pinBIdle", ringIndicate_n, 8'h01);
        rd(8'hF0);
        wr(8'hE1, 8'h01);
        auxPinBIn <= 1'b0;
    endtask : t_rawRing
    task automatic t_filtered();
        wr(8'hC6, 8'h07);
        for (int i = 0; i < 3; i++) begin
            wr(8'hF1, 8'h1F);
            level_n[i] <= 1'b0;
            cyc(3);
            level_n[i] <= 1'b1;
            cyc(30);
            chk("lonePulse", ringIndicate_n, 8'h01);
            burst[i] <= 1'b1;
            cyc(30);
            chk("notYet", ringIndicate_n, 8'h01);
            waitRing(1'b0, 200);
            rdChk(8'hF1, 8'(8'h01 << i), "trainStat");
            cyc(100);
            chk("trainHeld", ringIndicate_n, 8'h00);
            burst[i] <= 1'b0;
            waitRing(1'b1, 80);
            rd(8'hF0);
        end
    endtask : t_filtered
    task automatic t_wake();
        @(posedge clock);
        wakeLevelSrc <= 1'b1;
        #1;
        chk("levelOn", powerOnReq, 8'h01);
        @(posedge clock);
        wakeLevelSrc <= 1'b0;
        #1;
        chk("levelOff", powerOnReq, 8'h00);
        @(posedge clock);
        wakeEdgeSrc <= 1'b1;
        cyc(4);
        chk("edgeNoPower", powerOnReq, 8'h00);
        rdChk(8'hF0, 8'h02, "edgeLatch");
        rdChk(8'hF0, 8'h00, "latchCleared");
        wakeEdgeSrc <= 1'b0;
    endtask : t_wake
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        t_registers();
        t_pinDrive();
        t_pinInput();
        t_edgeIrq();
        t_rawRing();
        t_filtered();
        t_wake();
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge clock);
        errors++;
        end_of_test();
    end
endmodule : ring_wake_filter_gpio_cfg_tb
`default_nettype wire
